// ==== inc/cftr_pkg.sv ====
// constants and types shared by the converter fault telemetry block
package cftr_pkg;

   // ==========================================================
   // register offsets (command byte values)
   localparam logic [7:0]  FAULT_STATUS_AND_LOG_OFS   = 8'h79;
   localparam logic [7:0]  INPUT_VOLTAGE_READING_OFS  = 8'h88;
   localparam logic [7:0]  OUTPUT_VOLTAGE_READING_OFS = 8'h8b;

   // ==========================================================
   // values after reset, and the value read at unmapped offsets
   localparam logic [15:0] FAULT_STATUS_AND_LOG_RST   = 16'h0000;
   localparam logic [15:0] INPUT_VOLTAGE_READING_RST  = 16'h0000;
   localparam logic [15:0] OUTPUT_VOLTAGE_READING_RST = 16'h0000;
   localparam logic [15:0] UNMAPPED_READ_VALUE        = 16'h0000;

   // ==========================================================
   // status word fields
   localparam int          NUM_FAULTS        = 5;
   localparam int          LIVE_LSB          = 0;
   localparam int          LOG_LSB           = 8;
   localparam int          INPUT_LOW_POS     = 0;
   localparam int          INPUT_HIGH_POS    = 1;
   localparam int          REGULATION_POS    = 2;
   localparam int          OVERCURRENT_POS   = 3;
   localparam int          OVERTEMP_POS      = 4;

   // ==========================================================
   // two-wire address bytes (write form, bit 0 is read/write)
   localparam logic [7:0]  ADDR_BYTE_FLOAT   = 8'h02;
   localparam logic [7:0]  ADDR_BYTE_GND     = 8'h06;
   localparam logic [3:0]  BITS_PER_BYTE     = 4'h8;
   localparam logic [3:0]  LAST_TX_BIT       = 4'h7;

   // ==========================================================
   // protection thresholds, millivolts / milliamps / degrees
   localparam logic [15:0] INPUT_LOW_OFF_MV  = 16'h396c;
   localparam logic [15:0] INPUT_LOW_ON_MV   = 16'h3cf0;
   localparam logic [15:0] INPUT_HIGH_OFF_MV = 16'ha3ac;
   localparam logic [15:0] INPUT_HIGH_ON_MV  = 16'h94d4;
   localparam logic [15:0] OUTPUT_VOLTAGE_READING_NOMINAL_MV   = 16'h6d60;
   localparam logic [15:0] OUTPUT_VOLTAGE_READING_SHORT_MV     = 16'(32'(OUTPUT_VOLTAGE_READING_NOMINAL_MV) / 2);
   localparam logic [15:0] OUTPUT_VOLTAGE_READING_OVP_MV       = 16'(32'(OUTPUT_VOLTAGE_READING_NOMINAL_MV) * 6 / 5);
   localparam logic [15:0] OVERCURRENT_LIMIT_MA = 16'h36b0;
   localparam logic signed [15:0] OVERTEMP_TRIP_C = 16'sh007d;
   localparam logic signed [15:0] OVERTEMP_HYST_C = 16'sh000a;

   // ==========================================================
   // slave sequencer states, one-hot
   typedef enum logic [7:0] {
      ST_IDLE    = 8'h01,
      ST_ADDR    = 8'h02,
      ST_ADDR_ACK = 8'h04,
      ST_CMD     = 8'h08,
      ST_CMD_ACK = 8'h10,
      ST_TX      = 8'h20,
      ST_TX_ACK  = 8'h40,
      ST_IGNORE  = 8'h80
   } cftr_state_t;

endpackage

// ==== rtl/cftr_sync.sv ====
// three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
`default_nettype none
module cftr_sync
   import cftr_pkg::*;
#(
   parameter int               WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT  = '1
)
(
   // clock and reset
   input  wire logic             clk_in,
   input  wire logic             rst_n_in,
   // pins
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] level_out
);

   // ==========================================================
   // stages
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   logic [WIDTH-1:0] level_q;
   logic [WIDTH-1:0] agree;

   // a change counts only once stages two and three agree
   assign agree = ~(s2_q ^ s3_q);

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         meta_q  <= INIT;
         s2_q    <= INIT;
         s3_q    <= INIT;
         level_q <= INIT;
      end
      else
      begin
         meta_q  <= async_in;
         s2_q    <= meta_q;
         s3_q    <= s2_q;
         level_q <= (agree & s3_q) | (~agree & level_q);
      end
   end

   assign level_out = level_q;

endmodule
`default_nettype wire

// ==== rtl/cftr_fault_eval.sv ====
// live shutdown fault evaluation with hysteresis
`timescale 1ns/100ps
`default_nettype none
module cftr_fault_eval
   import cftr_pkg::*;
(
   // clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  rst_n_in,
   // measurements
   input  wire logic [15:0]           vin_mv_in,
   input  wire logic [15:0]           output_voltage_reading_mv_in,
   input  wire logic [15:0]           iout_ma_in,
   input  wire logic signed [15:0]    temp_c_in,
   input  wire logic                  remote_off_in,
   // results
   output logic      [NUM_FAULTS-1:0] live_out,
   output logic                       shutdown_out
);

   // ==========================================================
   // comparators
   logic [NUM_FAULTS-1:0] live_q;
   logic [NUM_FAULTS-1:0] live_d;
   logic                  shutdown_q;
   logic                  run_ok;
   logic signed [15:0]    temp_clear;

   // overtemperature clears only once cooled by the hysteresis step
   assign temp_clear = OVERTEMP_TRIP_C - OVERTEMP_HYST_C;

   // output only regulates while input is good and enabled
   assign run_ok = ~live_q[INPUT_LOW_POS] & ~live_q[INPUT_HIGH_POS] & ~remote_off_in;

   assign live_d[INPUT_LOW_POS]   = (vin_mv_in < INPUT_LOW_OFF_MV)
                                  | (live_q[INPUT_LOW_POS] & (vin_mv_in <= INPUT_LOW_ON_MV));
   assign live_d[INPUT_HIGH_POS]  = (vin_mv_in > INPUT_HIGH_OFF_MV)
                                  | (live_q[INPUT_HIGH_POS] & (vin_mv_in >= INPUT_HIGH_ON_MV));
   assign live_d[REGULATION_POS]  = run_ok
                                  & ((output_voltage_reading_mv_in < OUTPUT_VOLTAGE_READING_SHORT_MV) | (output_voltage_reading_mv_in > OUTPUT_VOLTAGE_READING_OVP_MV));
   assign live_d[OVERCURRENT_POS] = iout_ma_in > OVERCURRENT_LIMIT_MA;
   assign live_d[OVERTEMP_POS]    = (temp_c_in > OVERTEMP_TRIP_C)
                                  | (live_q[OVERTEMP_POS] & (temp_c_in >= temp_clear));

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         live_q     <= '0;
         shutdown_q <= 1'b1;
      end
      else
      begin
         live_q     <= live_d;
         shutdown_q <= (|live_d) | remote_off_in;
      end
   end

   assign live_out     = live_q;
   assign shutdown_out = shutdown_q;

endmodule
`default_nettype wire

// ==== rtl/cftr_top.sv ====
// converter fault telemetry register bank behind a two-wire read-only slave
//
// Operation
// - status word at 0x79: live low, log high
// - any live bit set means output off
// - bit 0 input low, with hysteresis
// - bit 1 input high, with hysteresis
// - bit 2 output voltage out of band, only while input good and remote on
// - bit 3 output current above shutdown limit
// - bit 4 temperature above trip point
// - bits 8 to 12 log past faults
// - log cleared only by power or remote off
// - input voltage reading at 0x88, 1 mV steps
// - output voltage reading at 0x8b, 1 mV steps
// - low byte holds low eight bits
// - slave only, 100 kHz, reads only
// - address 0x2 floating, 0x6 grounded
`timescale 1ns/100ps
`default_nettype none
module cftr_top
   import cftr_pkg::*;
(
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   // two-wire bus pins
   input  wire logic        scl_in,
   input  wire logic        sda_in,
   output logic             sda_out,
   output logic             sda_oe_n_out,
   // strap and control pins
   input  wire logic        addr_sel_in,
   input  wire logic        remote_on_n_in,
   // measurements from the converter front end
   input  wire logic [15:0] vin_mv_in,
   input  wire logic [15:0] output_voltage_reading_mv_in,
   input  wire logic [15:0] iout_ma_in,
   input  wire logic [15:0] temp_c_in,
   // converter control
   output logic             output_off_out
);

   // ==========================================================
   // reset release
   logic rst_meta_q;
   logic rst_sync_q;
   logic rst_n;

   always_ff @(posedge clk_in or negedge rst_n_in)
   begin
      if (!rst_n_in)
      begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   assign rst_n = rst_sync_q;

   // ==========================================================
   // pin synchronisers
   logic [3:0] pins_f;
   logic       scl_f;
   logic       sda_f;
   logic       remote_off;
   logic       addr_float;

   cftr_sync #(
      .WIDTH (4),
      .INIT  (4'hf)
   ) u_pin_sync (
      .clk_in    (clk_in),
      .rst_n_in  (rst_n),
      .async_in  ({addr_sel_in, remote_on_n_in, sda_in, scl_in}),
      .level_out (pins_f)
   );

   assign scl_f      = pins_f[0];
   assign sda_f      = pins_f[1];
   // floating on/off pin reads high and means off
   assign remote_off = pins_f[2];
   assign addr_float = pins_f[3];

   // ==========================================================
   // live faults and shutdown
   logic [NUM_FAULTS-1:0] live;

   cftr_fault_eval u_fault_eval (
      .clk_in        (clk_in),
      .rst_n_in      (rst_n),
      .vin_mv_in     (vin_mv_in),
      .output_voltage_reading_mv_in    (output_voltage_reading_mv_in),
      .iout_ma_in    (iout_ma_in),
      .temp_c_in     (temp_c_in),
      .remote_off_in (remote_off),
      .live_out      (live),
      .shutdown_out  (output_off_out)
   );

   // ==========================================================
   // register bank
   logic [NUM_FAULTS-1:0] log_q;
   logic [NUM_FAULTS-1:0] log_d;
   logic [15:0]           vin_q;
   logic [15:0]           output_voltage_reading_q;
   logic [15:0]           status_word;

   // a fault arriving with the clear still lands in the log
   assign log_d = (remote_off ? '0 : log_q) | live;

   // reserved bits are tied low
   assign status_word = {3'h0, log_q, 3'h0, live};

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         log_q  <= FAULT_STATUS_AND_LOG_RST[LOG_LSB +: NUM_FAULTS];
         vin_q  <= INPUT_VOLTAGE_READING_RST;
         output_voltage_reading_q <= OUTPUT_VOLTAGE_READING_RST;
      end
      else
      begin
         log_q  <= log_d;
         vin_q  <= vin_mv_in;
         output_voltage_reading_q <= output_voltage_reading_mv_in;
      end
   end

   // ==========================================================
   // bus events
   logic scl_prev_q;
   logic sda_prev_q;
   logic scl_rise;
   logic scl_fall;
   logic bus_start;
   logic bus_stop;

   assign scl_rise  = scl_f & ~scl_prev_q;
   assign scl_fall  = ~scl_f & scl_prev_q;
   assign bus_start = scl_f & scl_prev_q & sda_prev_q & ~sda_f;
   assign bus_stop  = scl_f & scl_prev_q & ~sda_prev_q & sda_f;

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_prev_q <= 1'b1;
         sda_prev_q <= 1'b1;
      end
      else
      begin
         scl_prev_q <= scl_f;
         sda_prev_q <= sda_f;
      end
   end

   // ==========================================================
   // read decode
   logic [7:0]  own_addr;
   logic        addr_match;
   logic        sel_status;
   logic        sel_vin;
   logic        sel_output_voltage_reading;
   logic [15:0] rd_word;

   logic [7:0]  ptr_q;
   logic [7:0]  shift_q;

   assign own_addr   = addr_float ? ADDR_BYTE_FLOAT : ADDR_BYTE_GND;
   assign addr_match = shift_q[7:1] == own_addr[7:1];
   assign sel_status = ptr_q == FAULT_STATUS_AND_LOG_OFS;
   assign sel_vin    = ptr_q == INPUT_VOLTAGE_READING_OFS;
   assign sel_output_voltage_reading   = ptr_q == OUTPUT_VOLTAGE_READING_OFS;
   assign rd_word    = sel_status ? status_word
                     : sel_vin    ? vin_q
                     : sel_output_voltage_reading   ? output_voltage_reading_q
                     : UNMAPPED_READ_VALUE;

   // ==========================================================
   // slave sequencer
   cftr_state_t state_q;
   cftr_state_t state_d;
   logic [3:0]  cnt_q;
   logic [3:0]  cnt_d;
   logic [7:0]  shift_d;
   logic [7:0]  ptr_d;
   logic [7:0]  tx_q;
   logic [7:0]  tx_d;
   logic [15:0] word_q;
   logic [15:0] word_d;
   logic        hi_q;
   logic        hi_d;
   logic        nack_q;
   logic        nack_d;
   logic        drive_q;
   logic        drive_d;
   logic [7:0]  next_byte;

   // low byte goes first, then high byte
   assign next_byte = hi_q ? word_q[15:8] : word_q[7:0];

   always_comb
   begin
      state_d = state_q;
      cnt_d   = cnt_q;
      shift_d = shift_q;
      ptr_d   = ptr_q;
      tx_d    = tx_q;
      word_d  = word_q;
      hi_d    = hi_q;
      nack_d  = nack_q;
      drive_d = drive_q;
      if (bus_stop)
      begin
         state_d = ST_IDLE;
         drive_d = 1'b0;
      end
      else if (bus_start)
      begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         drive_d = 1'b0;
      end
      else if (scl_rise)
      begin
         if (state_q == ST_ADDR || state_q == ST_CMD)
         begin
            shift_d = {shift_q[6:0], sda_f};
            cnt_d   = 4'(cnt_q + 4'h1);
         end
         if (state_q == ST_TX_ACK)
         begin
            nack_d = sda_f;
         end
      end
      else if (scl_fall)
      begin
         unique case (state_q)
            ST_ADDR:
            begin
               if (cnt_q == BITS_PER_BYTE)
               begin
                  // pair is captured whole so both bytes match
                  state_d = addr_match ? ST_ADDR_ACK : ST_IGNORE;
                  drive_d = addr_match;
                  word_d  = rd_word;
                  hi_d    = 1'b0;
               end
            end
            ST_ADDR_ACK:
            begin
               cnt_d = 4'h0;
               if (shift_q[0])
               begin
                  state_d = ST_TX;
                  tx_d    = next_byte;
                  drive_d = ~next_byte[7];
                  hi_d    = 1'b1;
               end
               else
               begin
                  state_d = ST_CMD;
                  drive_d = 1'b0;
               end
            end
            ST_CMD:
            begin
               if (cnt_q == BITS_PER_BYTE)
               begin
                  ptr_d   = shift_q;
                  state_d = ST_CMD_ACK;
                  drive_d = 1'b1;
               end
            end
            ST_CMD_ACK:
            begin
               // data bytes after the pointer are never acknowledged
               state_d = ST_IGNORE;
               drive_d = 1'b0;
            end
            ST_TX:
            begin
               if (cnt_q == LAST_TX_BIT)
               begin
                  state_d = ST_TX_ACK;
                  drive_d = 1'b0;
               end
               else
               begin
                  cnt_d   = 4'(cnt_q + 4'h1);
                  tx_d    = {tx_q[6:0], 1'b0};
                  drive_d = ~tx_q[6];
               end
            end
            ST_TX_ACK:
            begin
               if (nack_q)
               begin
                  state_d = ST_IGNORE;
               end
               else
               begin
                  state_d = ST_TX;
                  cnt_d   = 4'h0;
                  tx_d    = next_byte;
                  drive_d = ~next_byte[7];
                  hi_d    = ~hi_q;
               end
            end
            ST_IDLE,
            ST_IGNORE:
            begin
               state_d = state_q;
            end
            default:
            begin
               state_d = ST_IDLE;
               drive_d = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
         shift_q <= 8'h00;
         ptr_q   <= 8'h00;
         tx_q    <= 8'h00;
         word_q  <= 16'h0000;
         hi_q    <= 1'b0;
         nack_q  <= 1'b0;
         drive_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         shift_q <= shift_d;
         ptr_q   <= ptr_d;
         tx_q    <= tx_d;
         word_q  <= word_d;
         hi_q    <= hi_d;
         nack_q  <= nack_d;
         drive_q <= drive_d;
      end
   end

   // ==========================================================
   // open-drain pin: only ever pulls low, never drives high
   assign sda_out      = 1'b0;
   assign sda_oe_n_out = ~drive_q;

endmodule
`default_nettype wire

// ==== bench/cftr_top_assertions.sv ====
// port checker for the fault telemetry register bank
`timescale 1ns/100ps
`default_nettype none
module cftr_top_chk
   import cftr_pkg::*;
(
   // watched ports
   input  wire logic        clk_in,
   input  wire logic        rst_n_in,
   input  wire logic        scl_in,
   input  wire logic        sda_out,
   input  wire logic        sda_oe_n_out,
   input  wire logic        remote_on_n_in,
   input  wire logic [15:0] vin_mv_in,
   input  wire logic [15:0] output_voltage_reading_mv_in,
   input  wire logic [15:0] iout_ma_in,
   input  wire logic [15:0] temp_c_in,
   input  wire logic        output_off_out
);
   // ==========================================================
   // clocking
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!rst_n_in);

   // ==========================================================
   // bus pin
   chk_quiet_after_reset: assert property (
      $rose(rst_n_in) |-> sda_oe_n_out && output_off_out)
      else $error("outputs not quiet after reset");
   chk_pin_value_low: assert property (sda_out == 1'b0)
      else $error("open drain value not low");
   chk_change_scl_low: assert property ($changed(sda_oe_n_out) |-> !scl_in)
      else $error("data pin changed while bus clock high");

   // ==========================================================
   // shutdown causes, up to three register stages allowed; remote off must first hold for eight cycles
   chk_low_input_off: assert property (
      vin_mv_in < INPUT_LOW_OFF_MV |-> ##[1:3] output_off_out)
      else $error("low input did not turn output off");
   chk_high_input_off: assert property (
      vin_mv_in > INPUT_HIGH_OFF_MV |-> ##[1:3] output_off_out)
      else $error("high input did not turn output off");
   chk_output_voltage_reading_band_off: assert property (
      (output_voltage_reading_mv_in < OUTPUT_VOLTAGE_READING_SHORT_MV) || (output_voltage_reading_mv_in > OUTPUT_VOLTAGE_READING_OVP_MV) |-> ##[1:3] output_off_out)
      else $error("output voltage out of band did not turn output off");
   chk_current_off: assert property (
      iout_ma_in > OVERCURRENT_LIMIT_MA |-> ##[1:3] output_off_out)
      else $error("overcurrent did not turn output off");
   chk_temp_off: assert property (
      $signed(temp_c_in) > OVERTEMP_TRIP_C |-> ##[1:3] output_off_out)
      else $error("overtemperature did not turn output off");
   chk_remote_off: assert property (remote_on_n_in [*8] |-> output_off_out)
      else $error("remote off did not turn output off");
endmodule

bind cftr_top cftr_top_chk chk_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_in),
   .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out), .remote_on_n_in(remote_on_n_in),
   .vin_mv_in(vin_mv_in), .output_voltage_reading_mv_in(output_voltage_reading_mv_in), .iout_ma_in(iout_ma_in), .temp_c_in(temp_c_in),
   .output_off_out(output_off_out));
`default_nettype wire

// ==== bench/cftr_bus_master.sv ====
// two-wire bus master model that reads words from the bank
`timescale 1ns/100ps
`default_nettype none
module cftr_bus_master
   import cftr_pkg::*;
#(
   parameter int HALF = 16
)
(
   // clock
   input  wire logic        clk_in,
   // bus pins, data 1 means released
   output logic             scl_out,
   output logic             sda_out,
   input  wire logic        sda_in,
   // result of each read
   output logic             done_out,
   output logic [15:0]      word_out,
   output logic [2:0]       acks_out
);
   initial
   begin
      scl_out = 1'b1;
      sda_out = 1'b1;
      done_out = 1'b0;
      word_out = 16'h0000;
      acks_out = 3'h0;
   end

   // ==========================================================
   // pin phases; clock runs faster than nominal to keep runs short
   task automatic drv(input logic c, input logic d, input int n);
      @(posedge clk_in);
      scl_out <= c;
      sda_out <= d;
      repeat (n) @(posedge clk_in);
   endtask
   task automatic bitx(input logic b, output logic r);
      drv(1'b0, b, HALF / 2);
      drv(1'b1, b, HALF / 2);
      r = sda_in;
      drv(1'b1, b, HALF / 2);
      drv(1'b0, b, HALF / 2);
   endtask
   task automatic bytex(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic a);
      for (int i = 7; i >= 0; i--)
         bitx(d[i], q[i]);
      bitx(ak, a);
   endtask
   task automatic rs;
      drv(1'b0, 1'b1, HALF / 2);
      drv(1'b1, 1'b1, HALF);
      drv(1'b1, 1'b0, HALF);
      drv(1'b0, 1'b0, HALF / 2);
   endtask
   task automatic stp;
      drv(1'b0, 1'b0, HALF / 2);
      drv(1'b1, 1'b0, HALF);
      drv(1'b1, 1'b1, HALF);
   endtask

   // ==========================================================
   // pointer write then word read; never writes data bytes
   task automatic read_word(input logic [7:0] adr, input logic [7:0] cmd);
      logic [7:0] lo, hi, x;
      logic [2:0] a;
      logic       y;
      rs();
      bytex(adr, 1'b1, x, a[2]);
      bytex(cmd, 1'b1, x, a[1]);
      rs();
      bytex(adr | 8'h01, 1'b1, x, a[0]);
      bytex(8'hff, 1'b0, lo, y);
      bytex(8'hff, 1'b1, hi, y);
      stp();
      word_out <= {hi, lo};
      acks_out <= a;
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
   endtask

   // ==========================================================
   // pointer then one data byte, which must be refused
   task automatic write_try(input logic [7:0] adr, input logic [7:0] cmd, input logic [7:0] dat);
      logic [7:0] x;
      logic [2:0] a;
      rs();
      bytex(adr, 1'b1, x, a[2]);
      bytex(cmd, 1'b1, x, a[1]);
      bytex(dat, 1'b1, x, a[0]);
      stp();
      word_out <= 16'h0000;
      acks_out <= a;
      done_out <= 1'b1;
      @(posedge clk_in);
      done_out <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== bench/test_converter_fault_telemetry_regs.sv ====
// self-checking bench for the fault telemetry register bank
`timescale 1ns/100ps
`default_nettype none
module test_converter_fault_telemetry_regs
   import cftr_pkg::*;
;
   logic        clk_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        remote_on_n_in = 1'b0;
   logic        addr_sel_in = 1'b1;
   logic [15:0] vin_mv_in = 16'h6d60;
   logic [15:0] output_voltage_reading_mv_in = 16'h6d60;
   logic [15:0] iout_ma_in = 16'h03e8;
   logic [15:0] temp_c_in = 16'h0019;
   logic [15:0] rv, ro;
   logic [4:0]  log_v = 5'h00;
   logic [7:0]  wa = ADDR_BYTE_FLOAT;
   logic [18:0] exp_q[$];
   int          failures = 0;
   int          num_checks = 0;
   wire logic   scl_w, sda_m, sda_w, sda_o, oe_n, off, done;
   wire logic [15:0] word;
   wire logic [2:0]  acks;

   always #2.5 clk_in = ~clk_in;
   // pull-up wins unless the master or the device pulls low
   assign sda_w = sda_m & (oe_n | sda_o);

   cftr_top dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in), .scl_in(scl_w), .sda_in(sda_w),
      .sda_out(sda_o), .sda_oe_n_out(oe_n), .addr_sel_in(addr_sel_in),
      .remote_on_n_in(remote_on_n_in), .vin_mv_in(vin_mv_in), .output_voltage_reading_mv_in(output_voltage_reading_mv_in),
      .iout_ma_in(iout_ma_in), .temp_c_in(temp_c_in), .output_off_out(off));
   cftr_bus_master #(.HALF(16)) mst_u (.clk_in(clk_in), .scl_out(scl_w), .sda_out(sda_m),
      .sda_in(sda_w), .done_out(done), .word_out(word), .acks_out(acks));

   // ==========================================================
   // checking
   task automatic cmp(input logic [18:0] e, input logic [18:0] g);
      num_checks++;
      if (g !== e)
      begin
         failures++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask
   always @(posedge clk_in)
   begin
      if (done === 1'b1)
      begin
         if (exp_q.size() == 0)
            cmp('x, {acks, word});
         else
            cmp(exp_q.pop_front(), {acks, word});
      end
   end
   task automatic report_and_stop;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // ==========================================================
   // stimulus
   task automatic rd(input logic [7:0] a, input logic [7:0] c, input logic [15:0] w,
                     input logic [2:0] k);
      exp_q.push_back({k, w});
      mst_u.read_word(a, c);
      repeat (2) @(posedge clk_in);
   endtask
   task automatic step(input int f, input logic [15:0] v, input logic [4:0] lv);
      @(posedge clk_in);
      case (f)
         0: vin_mv_in <= v;
         1: output_voltage_reading_mv_in <= v;
         2: iout_ma_in <= v;
         default: temp_c_in <= v;
      endcase
      repeat (4) @(posedge clk_in);
      log_v = log_v | lv;
      rd(wa, FAULT_STATUS_AND_LOG_OFS, {3'h0, log_v, 3'h0, lv}, 3'h0);
   endtask
   task automatic wait_set(input int n);
      repeat (n) @(posedge clk_in);
   endtask

   initial
   begin
      repeat (100000) @(posedge clk_in);
      failures++;
      report_and_stop();
   end

   initial
   begin
      void'($urandom(99023));
      wait_set(8);
      rst_n_in <= 1'b1;
      wait_set(20);
      for (int k = 0; k < 3; k++)
      begin
         rv = 16'($urandom_range(37000, 16000));
         ro = 16'($urandom_range(33000, 15000));
         vin_mv_in <= rv;
         output_voltage_reading_mv_in <= ro;
         wait_set(4);
         rd(wa, INPUT_VOLTAGE_READING_OFS, rv, 3'h0);
         rd(wa, OUTPUT_VOLTAGE_READING_OFS, ro, 3'h0);
      end
      step(0, 16'h6d60, 5'h00);
      step(1, 16'h6d60, 5'h00);
      step(0, 16'h36b0, 5'h01);
      step(0, 16'h3a98, 5'h01);
      step(0, 16'h6d60, 5'h00);
      step(0, 16'ha410, 5'h02);
      step(0, 16'h9c40, 5'h02);
      step(0, 16'h6d60, 5'h00);
      step(1, 16'h32c8, 5'h04);
      step(1, 16'h84d0, 5'h04);
      step(1, 16'h6d60, 5'h00);
      step(2, 16'h3a98, 5'h08);
      step(2, 16'h03e8, 5'h00);
      step(3, 16'h0082, 5'h10);
      step(3, 16'h0078, 5'h10);
      step(3, 16'h0019, 5'h00);
      remote_on_n_in <= 1'b1;
      wait_set(10);
      log_v = 5'h00;
      rd(wa, FAULT_STATUS_AND_LOG_OFS, 16'h0000, 3'h0);
      remote_on_n_in <= 1'b0;
      wait_set(10);
      step(2, 16'h3a98, 5'h08);
      step(2, 16'h03e8, 5'h00);
      rst_n_in <= 1'b0;
      wait_set(8);
      rst_n_in <= 1'b1;
      wait_set(20);
      log_v = 5'h00;
      rd(wa, FAULT_STATUS_AND_LOG_OFS, 16'h0000, 3'h0);
      addr_sel_in <= 1'b0;
      wait_set(10);
      rd(ADDR_BYTE_FLOAT, INPUT_VOLTAGE_READING_OFS, 16'hffff, 3'h7);
      rd(ADDR_BYTE_GND, OUTPUT_VOLTAGE_READING_OFS, 16'h6d60, 3'h0);
      exp_q.push_back({3'h1, 16'h0000});
      mst_u.write_try(ADDR_BYTE_GND, FAULT_STATUS_AND_LOG_OFS, 8'h00);
      wait_set(2);
      rd(ADDR_BYTE_GND, 8'h8c, UNMAPPED_READ_VALUE, 3'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
